// *** hw/lcdcmd_pkg.sv ***
// Package for the LCD command interpreter: command codes, fields, types.
// Assumes a host and a display memory on the same clock.
package lcdcmd_pkg;

  // Command codes
  localparam logic [7:0] CMD_CURSOR_SHAPE_CMD = 8'h5D;
  localparam logic [7:0] CMD_DIR_RIGHT = 8'h4C;
  localparam logic [7:0] CMD_DIR_LEFT = 8'h4D;
  localparam logic [7:0] CMD_DIR_UP = 8'h4E;
  localparam logic [7:0] CMD_DIR_DOWN = 8'h4F;
  localparam logic [7:0] CMD_LAYER_OVERLAY_CMD = 8'h5B;
  localparam logic [7:0] CMD_HSCROLL = 8'h5A;
  localparam logic [7:0] CMD_CURSOR_ADDR_WRITE_CMD = 8'h46;
  localparam logic [7:0] CMD_CURSOR_ADDR_READ_CMD = 8'h47;
  localparam logic [7:0] CMD_MEMORY_WRITE_CMD = 8'h42;
  localparam logic [7:0] CMD_MEMORY_READ_CMD = 8'h43;

  // Parameter byte fields
  localparam int CRX_LSB = 0;
  localparam int CRY_LSB = 0;
  localparam int CM_BIT = 7;
  localparam int MX_LSB = 0;
  localparam int DM1_BIT = 2;
  localparam int DM2_BIT = 3;
  localparam int OV_BIT = 4;
  localparam int HS_LSB = 0;
  localparam int DIR_LSB = 0;

  // Direction codes
  localparam logic [1:0] DIR_RIGHT = 2'h0;
  localparam logic [1:0] DIR_LEFT = 2'h1;
  localparam logic [1:0] DIR_UP = 2'h2;
  localparam logic [1:0] DIR_DOWN = 2'h3;

  // Merge codes
  localparam logic [1:0] MX_OR = 2'h0;
  localparam logic [1:0] MX_XOR = 2'h1;
  localparam logic [1:0] MX_AND = 2'h2;
  localparam logic [1:0] MX_PRIO = 2'h3;

  // Reset values
  localparam logic [15:0] CSR_ADDR_RST = 16'h0000;
  localparam logic [3:0] CODE4_RST = 4'h0;
  localparam logic [3:0] CRY_RST = 4'h1;
  localparam logic [2:0] HS_RST = 3'h0;

  typedef struct packed {
    logic [3:0] cursor_width_code;
    logic [3:0] cursor_height_code;
    logic cursor_shape_select;
    logic [1:0] step_dir;
    logic [1:0] layer_merge_select;
    logic block_one_display_type;
    logic block_three_display_type;
    logic layer_count_select;
    logic [2:0] pixel_hscroll;
  } lcdcmd_cfg_t;

  typedef struct packed {
    logic we;
    logic re;
    logic [15:0] addr;
    logic [7:0] wdata;
  } lcdcmd_mem_t;

endpackage : lcdcmd_pkg

// *** hw/lcdcmd_top.sv ***
// Command interpreter for cursor, layer and memory access commands.
// Assumes host strobes and memory on core_clk; memory read data one
// cycle after the read strobe.
// Function
// - Cursor width code is width minus one, 1 to 16 pixels.
// - Cursor height code is lines minus one; zero code is illegal.
// - Height code is underline row or block extent from origin.
// - Shape bit 0 underline, 1 block; graphics needs block.
// - Codes 4C..4F step right, left, up, down; vertical by pitch.
// - Selected step applied after each host memory read or write.
// - Merge select picks OR, XOR-then-OR, AND-then-OR, priority-OR.
// - One composition method for all layers, none per screen block.
// - Priority-OR equals OR when no layer flashes.
// - Layers two, three graphics only; text layer one drops three.
// - Blocks 1 and 3 text on 0, graphics on 1; 2, 4 graphics.
// - Layer count bit 0 two layers, 1 three layers.
// - Whole screen shifts 0 to 7 pixels, never one layer.
// - 16-bit cursor address feeds memory write and read.
// - Address changes only by address write or auto step.
// - No direct host path to display memory.
// - Address read returns low byte then high byte.
// - Each data byte after memory write stored then address steps.
// - Memory read fetches to buffer; each host read steps, prefetches.
// - With cursor shown, read data comes two positions ahead.
`timescale 1ns/1ns

module lcdcmd_top #(
  parameter int ADDR_W = 16,
  parameter int PIX_W = 8
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic host_cmd_wr,
  input wire logic host_data_wr,
  input wire logic host_data_rd,
  input wire logic [7:0] host_wdata,
  output logic [7:0] host_rdata,
  output logic host_busy,
  input wire logic [7:0] address_pitch,
  input wire logic cursor_shown,
  output lcdcmd_pkg::lcdcmd_mem_t mem_req,
  input wire logic [7:0] mem_rdata,
  output lcdcmd_pkg::lcdcmd_cfg_t cfg,
  output logic three_layer_active,
  input wire logic [PIX_W-1:0] layer_one,
  input wire logic [PIX_W-1:0] layer_two,
  input wire logic [PIX_W-1:0] layer_three,
  input wire logic [2:0] layer_visible,
  output logic [PIX_W-1:0] composed_pixels
);

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_FORM_P1,
    ST_FORM_P2,
    ST_LAYER_OVERLAY_CMD_P1,
    ST_HS_P1,
    ST_CURSOR_ADDR_WRITE_CMD_LO,
    ST_CURSOR_ADDR_WRITE_CMD_HI,
    ST_MEMORY_WRITE_CMD,
    ST_MEMORY_READ_CMD,
    ST_CURSOR_ADDR_READ_CMD_LO,
    ST_CURSOR_ADDR_READ_CMD_HI
  } lcdcmd_state_t;

  // Address after one automatic step
  function automatic logic [ADDR_W-1:0] step_addr(
    input logic [ADDR_W-1:0] a,
    input logic [1:0] dir,
    input logic [7:0] pitch
  );
    logic [ADDR_W-1:0] p;
    p = ADDR_W'(pitch);
    case (dir)
      lcdcmd_pkg::DIR_RIGHT: step_addr = a + ADDR_W'(1);
      lcdcmd_pkg::DIR_LEFT: step_addr = a - ADDR_W'(1);
      lcdcmd_pkg::DIR_UP: step_addr = a - p;
      default: step_addr = a + p;
    endcase
  endfunction : step_addr

  lcdcmd_state_t state_r;
  lcdcmd_state_t state_nxt;
  lcdcmd_pkg::lcdcmd_cfg_t cfg_r;
  lcdcmd_pkg::lcdcmd_cfg_t cfg_nxt;
  logic [ADDR_W-1:0] cursor_address_r;
  logic [ADDR_W-1:0] cursor_address_nxt;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic fetch_pend_r;
  logic fetch_nxt;
  lcdcmd_pkg::lcdcmd_mem_t mem_r;
  lcdcmd_pkg::lcdcmd_mem_t mem_nxt;

  wire [ADDR_W-1:0] addr_step1;
  wire [ADDR_W-1:0] addr_step2;
  wire [ADDR_W-1:0] fetch_addr;
  wire is_dir_cmd;

  assign addr_step1 = step_addr(cursor_address_r, cfg_r.step_dir,
    address_pitch);
  assign addr_step2 = step_addr(addr_step1, cfg_r.step_dir,
    address_pitch);
  // Read source two steps ahead while the cursor is shown
  assign fetch_addr = cursor_shown ? addr_step2 : cursor_address_r;
  assign is_dir_cmd = (host_wdata[7:2] == lcdcmd_pkg::CMD_DIR_RIGHT[7:2]);

  // Command and parameter sequencing
  always_comb
  begin
    state_nxt = state_r;
    cfg_nxt = cfg_r;
    cursor_address_nxt = cursor_address_r;
    rdata_nxt = rdata_r;
    // Memory answers one cycle after the read strobe
    fetch_nxt = mem_r.re;
    mem_nxt = '0;
    mem_nxt.addr = 16'(cursor_address_r);
    if (fetch_pend_r)
    begin
      rdata_nxt = mem_rdata;
    end
    if (host_cmd_wr)
    begin
      // A new command aborts any open parameter or data sequence
      state_nxt = ST_IDLE;
      if (is_dir_cmd)
      begin
        cfg_nxt.step_dir = host_wdata[lcdcmd_pkg::DIR_LSB +: 2];
      end
      else
      begin
        case (host_wdata)
          lcdcmd_pkg::CMD_CURSOR_SHAPE_CMD: state_nxt = ST_FORM_P1;
          lcdcmd_pkg::CMD_LAYER_OVERLAY_CMD: state_nxt = ST_LAYER_OVERLAY_CMD_P1;
          lcdcmd_pkg::CMD_HSCROLL: state_nxt = ST_HS_P1;
          lcdcmd_pkg::CMD_CURSOR_ADDR_WRITE_CMD: state_nxt = ST_CURSOR_ADDR_WRITE_CMD_LO;
          lcdcmd_pkg::CMD_MEMORY_WRITE_CMD: state_nxt = ST_MEMORY_WRITE_CMD;
          lcdcmd_pkg::CMD_MEMORY_READ_CMD:
          begin
            state_nxt = ST_MEMORY_READ_CMD;
            mem_nxt.re = 1'b1;
            mem_nxt.addr = 16'(fetch_addr);
          end
          lcdcmd_pkg::CMD_CURSOR_ADDR_READ_CMD:
          begin
            state_nxt = ST_CURSOR_ADDR_READ_CMD_LO;
            rdata_nxt = cursor_address_r[7:0];
          end
          default: state_nxt = ST_IDLE;
        endcase
      end
    end
    else if (host_data_wr)
    begin
      case (state_r)
        ST_FORM_P1:
        begin
          cfg_nxt.cursor_width_code =
            host_wdata[lcdcmd_pkg::CRX_LSB +: 4];
          state_nxt = ST_FORM_P2;
        end
        ST_FORM_P2:
        begin
          cfg_nxt.cursor_height_code =
            host_wdata[lcdcmd_pkg::CRY_LSB +: 4];
          cfg_nxt.cursor_shape_select =
            host_wdata[lcdcmd_pkg::CM_BIT];
          state_nxt = ST_IDLE;
        end
        ST_LAYER_OVERLAY_CMD_P1:
        begin
          cfg_nxt.layer_merge_select =
            host_wdata[lcdcmd_pkg::MX_LSB +: 2];
          cfg_nxt.block_one_display_type =
            host_wdata[lcdcmd_pkg::DM1_BIT];
          cfg_nxt.block_three_display_type =
            host_wdata[lcdcmd_pkg::DM2_BIT];
          cfg_nxt.layer_count_select =
            host_wdata[lcdcmd_pkg::OV_BIT];
          state_nxt = ST_IDLE;
        end
        ST_HS_P1:
        begin
          cfg_nxt.pixel_hscroll =
            host_wdata[lcdcmd_pkg::HS_LSB +: 3];
          state_nxt = ST_IDLE;
        end
        ST_CURSOR_ADDR_WRITE_CMD_LO:
        begin
          cursor_address_nxt[7:0] = host_wdata;
          state_nxt = ST_CURSOR_ADDR_WRITE_CMD_HI;
        end
        ST_CURSOR_ADDR_WRITE_CMD_HI:
        begin
          cursor_address_nxt[15:8] = host_wdata;
          state_nxt = ST_IDLE;
        end
        ST_MEMORY_WRITE_CMD:
        begin
          mem_nxt.we = 1'b1;
          mem_nxt.wdata = host_wdata;
          cursor_address_nxt = addr_step1;
        end
        default: state_nxt = state_r;
      endcase
    end
    else if (host_data_rd)
    begin
      case (state_r)
        ST_MEMORY_READ_CMD:
        begin
          cursor_address_nxt = addr_step1;
          mem_nxt.re = 1'b1;
          mem_nxt.addr = 16'(cursor_shown ?
            step_addr(addr_step2, cfg_r.step_dir, address_pitch)
            : addr_step1);
        end
        ST_CURSOR_ADDR_READ_CMD_LO:
        begin
          rdata_nxt = cursor_address_r[15:8];
          state_nxt = ST_CURSOR_ADDR_READ_CMD_HI;
        end
        ST_CURSOR_ADDR_READ_CMD_HI: state_nxt = ST_IDLE;
        default: state_nxt = state_r;
      endcase
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      state_r <= ST_IDLE;
      cfg_r <= '{cursor_width_code: lcdcmd_pkg::CODE4_RST,
        cursor_height_code: lcdcmd_pkg::CRY_RST,
        cursor_shape_select: 1'b0,
        step_dir: lcdcmd_pkg::DIR_RIGHT,
        layer_merge_select: lcdcmd_pkg::MX_OR,
        block_one_display_type: 1'b0,
        block_three_display_type: 1'b0,
        layer_count_select: 1'b0,
        pixel_hscroll: lcdcmd_pkg::HS_RST};
      cursor_address_r <= ADDR_W'(lcdcmd_pkg::CSR_ADDR_RST);
      rdata_r <= 8'h00;
      fetch_pend_r <= 1'b0;
      mem_r <= '0;
    end
    else
    begin
      state_r <= state_nxt;
      cfg_r <= cfg_nxt;
      cursor_address_r <= cursor_address_nxt;
      rdata_r <= rdata_nxt;
      fetch_pend_r <= fetch_nxt;
      mem_r <= mem_nxt;
    end
  end

  assign cfg = cfg_r;
  assign mem_req = mem_r;
  assign host_rdata = rdata_r;
  assign host_busy = fetch_pend_r | mem_r.re;

  // Layer composition
  wire text_mode;
  wire use_l3;
  wire [PIX_W-1:0] l1v;
  wire [PIX_W-1:0] l2v;
  wire [PIX_W-1:0] l3v;
  wire [PIX_W-1:0] l3_raw;
  wire [PIX_W-1:0] prio;
  wire [PIX_W-1:0] comp;

  // Text in layer one forbids a third layer
  assign text_mode = ~cfg_r.block_one_display_type;
  assign use_l3 = cfg_r.layer_count_select & ~text_mode;
  assign three_layer_active = use_l3;
  assign l3_raw = use_l3 ? layer_three : '0;
  assign l1v = layer_visible[0] ? layer_one : '0;
  assign l2v = layer_visible[1] ? layer_two : '0;
  assign l3v = layer_visible[2] ? l3_raw : '0;
  // Set pixel of an upper layer hides lower ones even while blanked
  assign prio = l1v | (~layer_one & l2v)
    | (~layer_one & ~layer_two & l3v);

  assign comp =
    (cfg_r.layer_merge_select == lcdcmd_pkg::MX_OR) ? (l1v | l2v | l3v) :
    (cfg_r.layer_merge_select == lcdcmd_pkg::MX_XOR) ? ((l1v ^ l2v) | l3v) :
    (cfg_r.layer_merge_select == lcdcmd_pkg::MX_AND) ? ((l1v & l2v) | l3v) :
    prio;

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      composed_pixels <= '0;
    end
    else
    begin
      composed_pixels <= comp;
    end
  end

endmodule : lcdcmd_top

// *** tb/lcdcmd_monitor.sv ***
// Port checker for the command interpreter.
// Assumes one clock domain and a synchronous reset.
`timescale 1ns/1ns
module lcdcmd_monitor #(
  parameter int PIX_W = 8
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic host_cmd_wr,
  input wire logic host_data_wr,
  input wire logic host_data_rd,
  input wire logic [7:0] host_wdata,
  input wire logic host_busy,
  input wire lcdcmd_pkg::lcdcmd_mem_t mem_req,
  input wire lcdcmd_pkg::lcdcmd_cfg_t cfg,
  input wire logic three_layer_active,
  input wire logic [PIX_W-1:0] layer_one,
  input wire logic [PIX_W-1:0] layer_two,
  input wire logic [PIX_W-1:0] layer_three,
  input wire logic [2:0] layer_visible,
  input wire logic [PIX_W-1:0] composed_pixels
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  a_dir_decode:
  assert property (host_cmd_wr && host_wdata[7:2] == 6'h13
    |=> cfg.step_dir == $past(host_wdata[1:0])) else $error("bad dir");
  a_cmd_no_mem:
  assert property (host_cmd_wr && host_wdata != lcdcmd_pkg::CMD_MEMORY_READ_CMD
    |=> !mem_req.we && !mem_req.re) else $error("stray access");
  a_we_data:
  assert property (mem_req.we |-> $past(host_data_wr)
    && mem_req.wdata == $past(host_wdata)) else $error("bad write");
  a_re_cause:
  assert property (mem_req.re |-> $past(host_cmd_wr) || $past(host_data_rd)
    || $past(host_data_rd, 2)) else $error("stray read");
  a_busy_short:
  assert property (host_busy ##1 host_busy |=> !host_busy)
    else $error("busy too long");
  a_cfg_cause:
  assert property (!$stable(cfg) |-> $past(host_cmd_wr || host_data_wr))
    else $error("cfg changed alone");
  a_three_layer:
  assert property (three_layer_active == (cfg.layer_count_select
    && cfg.block_one_display_type)) else $error("bad layer count");
  a_or_compose:
  assert property (three_layer_active && layer_visible == 3'h7
    && cfg.layer_merge_select inside {2'h0, 2'h3} |=> composed_pixels
    == ($past(layer_one) | $past(layer_two) | $past(layer_three)))
    else $error("bad or merge");
  a_xor_compose:
  assert property (three_layer_active && cfg.layer_merge_select == 2'h1
    |=> composed_pixels == (($past(layer_one) ^ $past(layer_two))
    | $past(layer_three))) else $error("bad xor merge");
endmodule : lcdcmd_monitor

bind lcdcmd_top lcdcmd_monitor #(.PIX_W(PIX_W)) u_lcdcmd_monitor (
  .core_clk(core_clk), .sys_rst(sys_rst), .host_cmd_wr(host_cmd_wr),
  .host_data_wr(host_data_wr), .host_data_rd(host_data_rd),
  .host_wdata(host_wdata), .host_busy(host_busy), .mem_req(mem_req),
  .cfg(cfg), .three_layer_active(three_layer_active),
  .layer_one(layer_one), .layer_two(layer_two), .layer_three(layer_three),
  .layer_visible(layer_visible), .composed_pixels(composed_pixels));

// *** tb/lcdcmd_mem_model.sv ***
// Display memory model behind the interpreter's memory strobes.
// Assumes read data is taken one cycle after the read strobe.
`timescale 1ns/1ns
module lcdcmd_mem_model (
  input wire logic core_clk,
  input wire lcdcmd_pkg::lcdcmd_mem_t mem_req,
  output logic [7:0] mem_rdata
);
  logic [7:0] mem [logic [15:0]];
  initial mem_rdata = 8'h00;
  always @(posedge core_clk)
  begin
    if (mem_req.we === 1'b1)
      mem[mem_req.addr] = mem_req.wdata;
    if (mem_req.re === 1'b1)
      mem_rdata <= mem.exists(mem_req.addr) ? mem[mem_req.addr] : 8'h5A;
    else
      mem_rdata <= ~mem_rdata;
  end
endmodule : lcdcmd_mem_model

// *** tb/lcdcmd_top_tb.sv ***
// Testbench: host command sequences, settings and memory traffic checks.
// Assumes the memory model and the bound port checker.
`timescale 1ns/1ns
module lcdcmd_top_tb;
  logic core_clk = 0, sys_rst = 1, host_cmd_wr = 0, host_data_wr = 0;
  logic host_data_rd = 0, cursor_shown = 0, three_layer_active, host_busy;
  logic [7:0] host_wdata = 8'h00, address_pitch = 8'h28, host_rdata;
  logic [7:0] layer_one = 8'hC3, layer_two = 8'hA5, layer_three = 8'h18;
  logic [7:0] composed_pixels, mem_rdata;
  logic [7:0] cmp [4] = '{8'hFF, 8'h7E, 8'h99, 8'hFF};
  logic [2:0] layer_visible = 3'h7;
  lcdcmd_pkg::lcdcmd_mem_t mem_req;
  lcdcmd_pkg::lcdcmd_cfg_t cfg, exp_cfg;
  logic [23:0] wq [$];
  logic [15:0] s;
  int bad_count = 0, n_compared = 0, cyc = 0;
  always #25 core_clk = ~core_clk;
  lcdcmd_top u_lcdcmd_top (.core_clk(core_clk), .sys_rst(sys_rst),
    .host_cmd_wr(host_cmd_wr), .host_data_wr(host_data_wr),
    .host_data_rd(host_data_rd), .host_wdata(host_wdata),
    .host_rdata(host_rdata), .host_busy(host_busy),
    .address_pitch(address_pitch), .cursor_shown(cursor_shown),
    .mem_req(mem_req), .mem_rdata(mem_rdata), .cfg(cfg),
    .three_layer_active(three_layer_active), .layer_one(layer_one),
    .layer_two(layer_two), .layer_three(layer_three),
    .layer_visible(layer_visible), .composed_pixels(composed_pixels));
  lcdcmd_mem_model u_lcdcmd_mem_model (.core_clk(core_clk),
    .mem_req(mem_req), .mem_rdata(mem_rdata));
  always @(posedge core_clk)
  begin
    if (mem_req.we === 1'b1)
      wq.push_back({mem_req.addr, mem_req.wdata});
    cyc++;
    if (cyc == 6000)
    begin
      bad_count++;
      stop_test;
    end
  end
  task stop_test;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test
  task chk(input logic [31:0] got, input logic [31:0] want);
    n_compared++;
    if (got !== want)
    begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, want);
    end
  endtask : chk
  task wr(input logic c, input logic [7:0] b);
    @(posedge core_clk);
    host_cmd_wr <= c;
    host_data_wr <= !c;
    host_wdata <= b;
    @(posedge core_clk);
    host_cmd_wr <= 1'b0;
    host_data_wr <= 1'b0;
  endtask : wr
  task idle;
    int n;
    n = 0;
    repeat (2) @(negedge core_clk);
    while (host_busy !== 1'b0 && n < 20)
    begin
      @(negedge core_clk);
      n++;
    end
  endtask : idle
  task rd;
    @(posedge core_clk);
    host_data_rd <= 1'b1;
    @(posedge core_clk);
    host_data_rd <= 1'b0;
    idle;
  endtask : rd
  task cursor_addr_write_cmd(input logic [15:0] a);
    wr(1, lcdcmd_pkg::CMD_CURSOR_ADDR_WRITE_CMD);
    wr(0, a[7:0]);
    wr(0, a[15:8]);
  endtask : cursor_addr_write_cmd
  task cursor_addr_read_cmd(input logic [15:0] a);
    wr(1, lcdcmd_pkg::CMD_CURSOR_ADDR_READ_CMD);
    idle;
    chk(host_rdata, a[7:0]);
    rd;
    chk(host_rdata, a[15:8]);
  endtask : cursor_addr_read_cmd
  initial
  begin
    repeat (3) @(posedge core_clk);
    sys_rst <= 1'b0;
    idle;
    exp_cfg = '0;
    exp_cfg.cursor_height_code = lcdcmd_pkg::CRY_RST;
    chk(32'(cfg), 32'(exp_cfg));
    cursor_addr_read_cmd(16'h0000);
    wr(1, lcdcmd_pkg::CMD_CURSOR_SHAPE_CMD);
    wr(0, 8'h0F);
    wr(0, 8'h8E);
    idle;
    chk({cfg.cursor_shape_select, cfg.cursor_width_code,
      cfg.cursor_height_code}, 9'h1FE);
    wr(1, lcdcmd_pkg::CMD_CURSOR_SHAPE_CMD);
    wr(0, 8'h00);
    wr(0, 8'h01);
    idle;
    chk({cfg.cursor_shape_select, cfg.cursor_width_code,
      cfg.cursor_height_code}, 9'h001);
    for (int m = 0; m < 4; m++)
    begin
      wr(1, lcdcmd_pkg::CMD_LAYER_OVERLAY_CMD);
      wr(0, {3'h0, 3'h7, m[1:0]});
      idle;
      chk(three_layer_active, 1'b1);
      chk(composed_pixels, cmp[m]);
    end
    @(posedge core_clk);
    layer_visible <= 3'h6;
    idle;
    chk(composed_pixels, 8'h3C);
    wr(1, lcdcmd_pkg::CMD_LAYER_OVERLAY_CMD);
    wr(0, 8'h1C);
    idle;
    chk(composed_pixels, 8'hBD);
    @(posedge core_clk);
    layer_visible <= 3'h7;
    wr(1, lcdcmd_pkg::CMD_LAYER_OVERLAY_CMD);
    wr(0, 8'h11);
    idle;
    chk({three_layer_active, composed_pixels}, 9'h066);
    wr(1, lcdcmd_pkg::CMD_HSCROLL);
    wr(0, 8'h07);
    idle;
    chk(cfg.pixel_hscroll, 3'h7);
    for (int d = 0; d < 4; d++)
    begin
      s = d == 0 ? 16'h1 : d == 1 ? 16'hFFFF : d == 2 ? 16'hFFD8 : 16'h28;
      wr(1, 8'h4C + d[7:0]);
      cursor_addr_write_cmd(16'h1234);
      wr(1, lcdcmd_pkg::CMD_MEMORY_WRITE_CMD);
      wr(0, 8'hA0);
      wr(0, 8'hA1);
      idle;
      chk(cfg.step_dir, d);
      chk(wq.pop_front(), {16'h1234, 8'hA0});
      chk(wq.pop_front(), {16'h1234 + s, 8'hA1});
      cursor_addr_read_cmd(16'h1234 + 2 * s);
    end
    wr(1, lcdcmd_pkg::CMD_DIR_RIGHT);
    cursor_addr_write_cmd(16'h0100);
    wr(1, lcdcmd_pkg::CMD_MEMORY_WRITE_CMD);
    wr(0, 8'h11);
    wr(0, 8'h22);
    wr(0, 8'h33);
    wr(0, 8'h44);
    cursor_addr_write_cmd(16'h0100);
    wr(1, lcdcmd_pkg::CMD_MEMORY_READ_CMD);
    idle;
    chk(host_rdata, 8'h11);
    rd;
    chk(host_rdata, 8'h22);
    @(posedge core_clk);
    cursor_shown <= 1'b1;
    cursor_addr_write_cmd(16'h0100);
    wr(1, lcdcmd_pkg::CMD_MEMORY_READ_CMD);
    idle;
    chk(host_rdata, 8'h33);
    rd;
    chk(host_rdata, 8'h44);
    stop_test;
  end
endmodule : lcdcmd_top_tb
